// *** hw/opw_watchdog.sv ***
// Purpose: Watchdog with Avalon-MM register access
// Assumes: One oscillator clock, mclk_i, at 250 MHz
// Notes:   Timeout drives a chip reset and the reset pin
//
// Behaviour
// - 6-bit counter clocked by carry into prescaler bit 12
// - Overflow after timeout raises chip reset
// - Any write to service location restarts
// - Reset pin low 32 cycles, cause flag
// - Service clears prescaler bits 12 to 4
// - Service location reads reset vector low
// - Power-on clears prescaler after 4096 cycles
// - Internal reset clears both counters
// - Reset vector fetch clears prescaler
// - Config disable bit stops watchdog resets
// - Monitor mode plus high voltage disables
// - Break plus high voltage on reset disables
// - Counting continues during wait mode
// - Stop mode gates the prescaler clock
// - Timeout never raises a processor interrupt
// - Counts oscillator clock cycles
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module opw_watchdog
    import opw_pkg::*;
(
    // Clock and reset
    input  wire logic                       mclk_i,
    input  wire logic                       arst_n_i,
    // Avalon-MM slave
    input  wire logic [opw_pkg::ADDR_W-1:0] avs_address_i,
    input  wire logic                       avs_read_i,
    input  wire logic                       avs_write_i,
    input  wire logic [opw_pkg::DATA_W-1:0] avs_writedata_i,
    input  wire logic [opw_pkg::BE_W-1:0]   avs_byteenable_i,
    output logic      [opw_pkg::DATA_W-1:0] avs_readdata_o,
    output logic                            avs_waitrequest_o,
    // System side
    input  wire opw_pkg::opw_mode_t         mode_i,
    input  wire logic [7:0]                 vec_low_i,
    output logic                            chip_reset_o,
    // Pins: high voltage sense and open-drain reset
    input  wire logic                       hv_irq_pin_i,
    input  wire logic                       hv_rst_pin_i,
    input  wire logic                       rst_pin_i,
    output logic                            rst_pin_o,
    output logic                            rst_pin_oe_o,
    // Event interrupt
    output logic                            irq_o
);
    import opw_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Declarations

    opw_state_t         s_reg;     // Local state; counters and synchronisers keep their own
    opw_state_t         s_next;    // Next state
    logic [2:0]         pin_sync;  // Clean pin levels
    logic               hv_irq;    // High voltage on interrupt pin
    logic               hv_rst;    // High voltage on reset pin
    logic               rst_lvl;   // Reset pin level
    logic [PRE_W-1:0]   pre_cnt;   // Prescaler view
    logic [WD_W-1:0]    wd_cnt;    // Watchdog count view
    logic               ovf;       // Overflow pulse
    logic               req;       // Bus request present
    logic               take;      // Request accepted this edge
    logic               wr_take;   // Write accepted
    logic               svc_wr;    // Service write accepted
    logic               wd_dis;    // Watchdog disabled now
    logic               fire;      // Reset to issue
    logic               clr_all;   // Counter internal reset
    logic               clr_pre;   // Prescaler clear
    logic [DATA_W-1:0]  rd_val;    // Read mux output
    logic [EV_W-1:0]    ev;        // Events this cycle

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Address match for one register
    function automatic logic hit(input logic [ADDR_W-1:0] a);
        return avs_address_i == a;
    endfunction

    // Sticky flags: set wins over write-one clear
    function automatic logic [EV_W-1:0] w1c(
        input logic [EV_W-1:0] cur,
        input logic [EV_W-1:0] set,
        input logic [EV_W-1:0] clr
    );
        return set | (cur & ~clr);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    // Pins are asynchronous to the oscillator clock
    opw_sync #(
        .W (3)
    ) u_sync (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .pin_i    ({hv_irq_pin_i, hv_rst_pin_i, rst_pin_i}),
        .val_o    (pin_sync)
    );

    assign hv_irq  = pin_sync[2];
    assign hv_rst  = pin_sync[1];
    assign rst_lvl = pin_sync[0];

    ////////////////////////////////////////////////////////////////////
    // Counters

    // Internal reset covers the system request and our own pulse
    assign clr_all = mode_i.int_reset | s_reg.chip_rst;

    // Power-on and vector fetch clears of the prescaler
    assign clr_pre = s_reg.por_clr | mode_i.vfetch;

    opw_counter #(
        .PW   (PRE_W),
        .WW   (WD_W),
        .TAP  (PRE_TAP),
        .KEEP (SVC_KEEP)
    ) u_cnt (
        .mclk_i    (mclk_i),
        .arst_n_i  (arst_n_i),
        .run_i     (!mode_i.stop),
        .clr_all_i (clr_all),
        .clr_pre_i (clr_pre),
        .svc_i     (svc_wr),
        .pre_o     (pre_cnt),
        .wd_o      (wd_cnt),
        .ovf_o     (ovf)
    );

    ////////////////////////////////////////////////////////////////////
    // Bus handshake

    // One wait cycle per request, then the answer
    assign req               = avs_read_i | avs_write_i;
    assign take              = req & s_reg.ack;
    assign wr_take           = take & avs_write_i;
    assign avs_waitrequest_o = req & ~s_reg.ack;

    // Any data value to the service location counts
    assign svc_wr = wr_take & hit(ADDR_SVC);

    ////////////////////////////////////////////////////////////////////
    // Disable and reset decision

    // Config bit, monitor and break high-voltage conditions
    assign wd_dis = s_reg.cfg_dis
                  | (mode_i.monitor & (hv_irq | hv_rst))
                  | (mode_i.brk & hv_rst);

    // Counter already drops overflow on a service write
    assign fire = ovf & ~wd_dis & ~svc_wr;

    // Events that feed the interrupt, timeout is not one of them
    always_comb
    begin
        ev         = '0;
        ev[EV_SVC] = svc_wr;
        ev[EV_POR] = s_reg.por_clr;
    end

    ////////////////////////////////////////////////////////////////////
    // Read mux

    // Registered at the wait cycle, stands at the taking edge
    always_comb
    begin
        rd_val = '0;
        if (hit(ADDR_SVC))
            rd_val[7:0] = vec_low_i;
        else if (hit(ADDR_CTRL))
            rd_val[CTRL_DIS] = s_reg.cfg_dis;
        else if (hit(ADDR_STAT))
        begin
            rd_val[STAT_CAUSE] = s_reg.cause;
            rd_val[STAT_DIS]   = wd_dis;
            rd_val[STAT_STOP]  = mode_i.stop;
            rd_val[STAT_PIN]   = rst_lvl;
        end
        else if (hit(ADDR_ISTA))
            rd_val[EV_W-1:0] = s_reg.ista;
        else if (hit(ADDR_IMSK))
            rd_val[EV_W-1:0] = s_reg.imask;
        else if (hit(ADDR_CNT))
        begin
            rd_val[PRE_W-1:0]                = pre_cnt;
            rd_val[CNT_WD_LSB+WD_W-1:CNT_WD_LSB] = wd_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        s_next          = s_reg;
        s_next.chip_rst = 1'b0;
        s_next.por_clr  = 1'b0;

        // Bus answer sequencing
        if (take)
            s_next.ack = 1'b0;
        else if (req)
        begin
            s_next.ack   = 1'b1;
            s_next.rdata = rd_val;
        end

        // Config and mask writes, low byte lane
        if (wr_take && avs_byteenable_i[0])
        begin
            if (hit(ADDR_CTRL))
                s_next.cfg_dis = avs_writedata_i[CTRL_DIS];
            if (hit(ADDR_IMSK))
                s_next.imask = avs_writedata_i[EV_W-1:0];
        end

        // Event flags, set wins over clear
        s_next.ista = w1c(s_reg.ista, ev,
            (wr_take && avs_byteenable_i[0] && hit(ADDR_ISTA))
                ? avs_writedata_i[EV_W-1:0] : '0);

        // Cause flag, clear by writing one
        if (wr_take && avs_byteenable_i[0] && hit(ADDR_STAT)
            && avs_writedata_i[STAT_CAUSE])
            s_next.cause = 1'b0;

        // Timeout: chip reset, pin low, cause flag
        if (fire)
        begin
            s_next.chip_rst = 1'b1;
            s_next.pin_cnt  = PIN_CNT_W'(RST_PIN_CYCLES);
            s_next.cause    = 1'b1;
        end
        else if (s_reg.pin_cnt != '0)
            s_next.pin_cnt = s_reg.pin_cnt - 1'b1;

        // One-shot prescaler clear after power-up
        if (!s_reg.por_done)
        begin
            if (s_reg.por_cnt == POR_CNT_W'(POR_CYCLES - 1))
            begin
                s_next.por_done = 1'b1;
                s_next.por_clr  = 1'b1;
            end
            else
                s_next.por_cnt = s_reg.por_cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    // Read data from the register
    assign avs_readdata_o = s_reg.rdata;

    // Chip reset pulse, one per overflow that is neither disabled nor met by a service write
    assign chip_reset_o = s_reg.chip_rst;

    // Open-drain reset pin: only ever pulled low
    assign rst_pin_o    = 1'b0;
    assign rst_pin_oe_o = s_reg.pin_cnt != '0;

    // Level interrupt from unmasked sticky events
    assign irq_o = |(s_reg.ista & s_reg.imask);

endmodule
`default_nettype wire

// *** hw/opw_pkg.sv ***
// Purpose: Shared constants and types of the watchdog block
// Assumes: Avalon-MM byte addresses, 32-bit data
// Notes:   Only definitions live here
package opw_pkg;

    ////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int ADDR_W = 18;                 // Byte address width
    localparam int DATA_W = 32;                 // Bus data width
    localparam int BE_W   = 4;                  // Byte enables

    ////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam logic [ADDR_W-1:0] SVC_INDEX = 18'h0FFFF; // Service index
    localparam logic [ADDR_W-1:0] ADDR_SVC  = SVC_INDEX << 2;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 18'h00000; // Config
    localparam logic [ADDR_W-1:0] ADDR_STAT = 18'h00004; // Reset cause
    localparam logic [ADDR_W-1:0] ADDR_ISTA = 18'h00008; // Event status
    localparam logic [ADDR_W-1:0] ADDR_IMSK = 18'h0000C; // Event mask
    localparam logic [ADDR_W-1:0] ADDR_CNT  = 18'h00010; // Counter view

    ////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CTRL_DIS   = 0;  // Disable bit in config
    localparam int STAT_CAUSE = 0;  // Watchdog cause flag
    localparam int STAT_DIS   = 1;  // Watchdog currently disabled
    localparam int STAT_STOP  = 2;  // Prescaler gated by stop
    localparam int STAT_PIN   = 3;  // Sampled reset pin level
    localparam int EV_SVC     = 0;  // Service write seen
    localparam int EV_POR     = 1;  // Power-on prescaler clear done
    localparam int EV_W       = 2;  // Event count
    localparam int CNT_WD_LSB = 16; // Watchdog count in counter view

    ////////////////////////////////////////////////////////////////////
    // Counter shape and timing
    localparam int PRE_W    = 13;   // System prescaler width
    localparam int WD_W     = 6;    // Watchdog counter width
    localparam int PRE_TAP  = 12;   // Prescaler bit whose toggle counts
    localparam int SVC_KEEP = 4;    // Low prescaler bits kept by service
    localparam int TIMEOUT_CYCLES = 2**18 - 2**4; // Nominal timeout
    localparam int RST_PIN_CYCLES = 32;   // Reset pin low time
    localparam int POR_CYCLES     = 4096; // Power-on prescaler clear
    localparam int PIN_CNT_W      = $clog2(RST_PIN_CYCLES + 1);
    localparam int POR_CNT_W      = $clog2(POR_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////
    // System mode inputs, all on the oscillator clock
    typedef struct packed {
        logic stop;      // Stop mode, prescaler clock off
        logic monitor;   // Monitor mode
        logic brk;       // Break interrupt active
        logic vfetch;    // Reset vector on the data bus
        logic int_reset; // Internal reset from the system
    } opw_mode_t;

    // Main module state
    typedef struct packed {
        logic                  ack;      // Bus answer pending
        logic [DATA_W-1:0]     rdata;    // Read data
        logic                  cfg_dis;  // Config disable bit
        logic                  cause;    // Watchdog cause flag
        logic [EV_W-1:0]       ista;     // Sticky events
        logic [EV_W-1:0]       imask;    // Event mask
        logic [PIN_CNT_W-1:0]  pin_cnt;  // Reset pin low countdown
        logic                  chip_rst; // Chip reset pulse
        logic [POR_CNT_W-1:0]  por_cnt;  // Power-on count
        logic                  por_done; // Power-on clear issued
        logic                  por_clr;  // Power-on clear pulse
    } opw_state_t;

endpackage

// *** hw/opw_sync.sv ***
// Purpose: Three-flop synchroniser with agreement filter
// Assumes: Inputs come from pins, asynchronous to mclk_i
// Notes:   Output changes once flops two and three agree
`timescale 1ns/1ps
`default_nettype none
module opw_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         mclk_i,
    input  wire logic         arst_n_i,
    // Pin side and clean side
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] val_o
);
    typedef struct packed {
        logic [W-1:0] s1;  // First stage, read by s2 only
        logic [W-1:0] s2;  // Second stage
        logic [W-1:0] s3;  // Third stage
        logic [W-1:0] val; // Filtered value
    } opw_sync_t;

    opw_sync_t s_reg;
    opw_sync_t s_next;

    // Shift and take agreed bits
    always_comb
    begin
        s_next     = s_reg;
        s_next.s1  = pin_i;
        s_next.s2  = s_reg.s1;
        s_next.s3  = s_reg.s2;
        s_next.val = (s_reg.s2 & ~(s_reg.s2 ^ s_reg.s3))
                   | (s_reg.val & (s_reg.s2 ^ s_reg.s3));
    end

    // State register
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign val_o = s_reg.val;
endmodule
`default_nettype wire

// *** hw/opw_counter.sv ***
// Purpose: System prescaler and watchdog counter
// Assumes: Single oscillator clock
// Notes:   Overflow flag is a registered one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module opw_counter #(
    parameter int PW   = 13,
    parameter int WW   = 6,
    parameter int TAP  = 12,
    parameter int KEEP = 4
) (
    // Clock and reset
    input  wire logic          mclk_i,
    input  wire logic          arst_n_i,
    // Control
    input  wire logic          run_i,     // Prescaler clock on
    input  wire logic          clr_all_i, // Internal reset
    input  wire logic          clr_pre_i, // Prescaler clear
    input  wire logic          svc_i,     // Service write
    // Status
    output logic      [PW-1:0] pre_o,
    output logic      [WW-1:0] wd_o,
    output logic               ovf_o
);
    typedef struct packed {
        logic [PW-1:0] pre; // System prescaler
        logic [WW-1:0] wd;  // Watchdog counter
        logic          ovf; // Overflow pulse
    } opw_cnt_t;

    opw_cnt_t s_reg;
    opw_cnt_t s_next;

    // Counting, clears and overflow
    always_comb
    begin
        s_next     = s_reg;
        s_next.ovf = 1'b0;
        if (clr_all_i)
        begin
            s_next.pre = '0;
            s_next.wd  = '0;
        end
        else
        begin
            if (run_i)
            begin
                s_next.pre = s_reg.pre + 1'b1;
                if (&s_reg.pre[TAP-1:0])
                begin
                    s_next.wd = s_reg.wd + 1'b1;
                    if (&s_reg.wd)
                        s_next.ovf = 1'b1;
                end
            end
            if (clr_pre_i)
                s_next.pre = '0;
            if (svc_i)
            begin
                s_next.wd            = '0;
                s_next.pre[PW-1:KEEP] = '0;
                s_next.ovf           = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign pre_o = s_reg.pre;
    assign wd_o  = s_reg.wd;
    assign ovf_o = s_reg.ovf;
endmodule
`default_nettype wire

// *** sim/opw_watchdog_checker.sv ***
// Purpose: Port-level assertions for the watchdog
// Assumes: One clock mclk_i, async active-low reset
// Notes:   Bound into opw_watchdog after the module
`timescale 1ns/1ps
`default_nettype none
module opw_watchdog_checker
    import opw_pkg::*;
(
    // Clock and reset
    input  wire logic                       mclk_i,
    input  wire logic                       arst_n_i,
    // Bus handshake
    input  wire logic                       avs_read_i,
    input  wire logic                       avs_write_i,
    input  wire logic                       avs_waitrequest_o,
    input  wire logic [opw_pkg::DATA_W-1:0] avs_readdata_o,
    // System and pins
    input  wire opw_pkg::opw_mode_t         mode_i,
    input  wire logic                       hv_irq_pin_i,
    input  wire logic                       hv_rst_pin_i,
    input  wire logic                       chip_reset_o,
    input  wire logic                       rst_pin_o,
    input  wire logic                       rst_pin_oe_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    ////////////////////////////////////////////////////////////////////
    logic       req;        // Any bus request
    logic [6:0] oe_cnt_reg; // Cycles the reset pin has been driven
    assign req = avs_read_i | avs_write_i;

    // Count pin drive cycles, restart when released
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            oe_cnt_reg <= '0;
        else if (rst_pin_oe_o && oe_cnt_reg != 7'h7F)
            oe_cnt_reg <= oe_cnt_reg + 7'h01;
        else if (!rst_pin_oe_o)
            oe_cnt_reg <= '0;
    end

    ////////////////////////////////////////////////////////////////////
    pin_len_a: assert property ($fell(rst_pin_oe_o) |-> oe_cnt_reg == 7'h20)
        else $error("reset pin low time wrong");
    oe_cap_a: assert property (oe_cnt_reg <= 7'h20)
        else $error("reset pin held too long");
    pin_start_a: assert property (chip_reset_o |-> rst_pin_oe_o && !$past(rst_pin_oe_o))
        else $error("reset pin not started with chip reset");
    pulse_one_a: assert property (chip_reset_o |=> !chip_reset_o)
        else $error("chip reset longer than one cycle");
    pin_drive_a: assert property (!rst_pin_o)
        else $error("reset pin driven high");
    idle_ready_a: assert property (!req |-> !avs_waitrequest_o)
        else $error("waitrequest without request");
    one_wait_a: assert property (req && avs_waitrequest_o ##1 req |-> !avs_waitrequest_o)
        else $error("more than one wait cycle");
    rdata_hold_a: assert property (!req |=> $stable(avs_readdata_o))
        else $error("read data changed while idle");
    stop_quiet_a: assert property (mode_i.stop [*8] |-> !chip_reset_o)
        else $error("timeout during stop");
    mon_off_a: assert property ((mode_i.monitor && hv_irq_pin_i) [*6] |-> !chip_reset_o)
        else $error("timeout in monitor with high voltage");
    brk_off_a: assert property ((mode_i.brk && hv_rst_pin_i) [*6] |-> !chip_reset_o)
        else $error("timeout in break with high voltage");
endmodule

bind opw_watchdog opw_watchdog_checker opw_watchdog_checker_i (
    .mclk_i            (mclk_i),
    .arst_n_i          (arst_n_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_waitrequest_o (avs_waitrequest_o),
    .avs_readdata_o    (avs_readdata_o),
    .mode_i            (mode_i),
    .hv_irq_pin_i      (hv_irq_pin_i),
    .hv_rst_pin_i      (hv_rst_pin_i),
    .chip_reset_o      (chip_reset_o),
    .rst_pin_o         (rst_pin_o),
    .rst_pin_oe_o      (rst_pin_oe_o)
);
`default_nettype wire

// *** sim/opw_watchdog_test.sv ***
// Purpose: Self-checking bench for the watchdog
// Assumes: 250 MHz clock, reset pin pulled up
// Notes:   One full timeout is run, about 270k cycles
`timescale 1ns/1ps
`default_nettype none
module opw_watchdog_test;
    import opw_pkg::*;

    ////////////////////////////////////////////////////////////////////
    logic              mclk, arst_n, rd, wr, wreq, chip_rst;
    logic              hv_irq, hv_rst, pin_w, pin_o, pin_oe, irq;
    logic [ADDR_W-1:0] adr;
    logic [31:0]       wdat, rdat, q;
    logic [3:0]        be;
    logic [7:0]        vec;
    opw_mode_t         mode;
    int                cyc = 0;
    int                err_count = 0;
    int                n_tests = 0;
    int                seed, tk, t0, p1, g, n, i;
    logic [ADDR_W-1:0] ra [5] = '{ADDR_CTRL, ADDR_STAT, ADDR_ISTA, ADDR_IMSK, 18'h00020};
    logic [31:0]       re [5] = '{32'h0, 32'h8, 32'h0, 32'h0, 32'h0};

    // Pulled-up reset pin, low while the block drives it
    assign pin_w = pin_oe ? 1'b0 : 1'b1;

    opw_watchdog opw_watchdog_i (
        .mclk_i (mclk), .arst_n_i (arst_n), .avs_address_i (adr), .avs_read_i (rd),
        .avs_write_i (wr), .avs_writedata_i (wdat), .avs_byteenable_i (be),
        .avs_readdata_o (rdat), .avs_waitrequest_o (wreq), .mode_i (mode),
        .vec_low_i (vec), .chip_reset_o (chip_rst), .hv_irq_pin_i (hv_irq),
        .hv_rst_pin_i (hv_rst), .rst_pin_i (pin_w), .rst_pin_o (pin_o),
        .rst_pin_oe_o (pin_oe), .irq_o (irq)
    );

    // Clock and cycle count
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////
    // Linear timeout position from the counter view
    function automatic int pos(input logic [31:0] c);
        return int'(c[21:16]) * 4096 + int'(c[11:0]);
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One Avalon transfer; held until waitrequest is low at an edge
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int k;
        k = 0;
        adr <= a;
        wr <= w;
        rd <= !w;
        wdat <= d;
        @(posedge mclk);
        while (wreq !== 1'b0 && k < 50)
        begin
            @(posedge mclk);
            k++;
        end
        if (k == 50)
            err_count++;
        tk = cyc;
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        repeat (300000) @(posedge mclk);
        err_count++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        seed = 32'h57F7DE6E;
        {rd, wr, hv_irq, hv_rst, arst_n} = '0;
        mode = '0;
        vec = 8'h00;
        be = 4'hF;
        adr = '0;
        wdat = '0;
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (6) @(posedge mclk);
        // Reset values, unmapped write ignored
        bus(1'b1, 18'h00020, 32'hFFFFFFFF);
        for (i = 0; i < 5; i++)
        begin
            bus(1'b0, ra[i], 32'h0);
            chk(q, re[i]);
        end
        // Power-on prescaler clear and its event
        while (cyc < 4300) @(posedge mclk);
        bus(1'b0, ADDR_CNT, 32'h0);
        chk(32'(q[12:0] < 13'h0200), 32'h1);
        bus(1'b0, ADDR_ISTA, 32'h0);
        chk(q, 32'h1 << EV_POR);
        bus(1'b1, ADDR_IMSK, 32'h1 << EV_POR);
        @(posedge mclk);
        chk(32'(irq), 32'h1);
        bus(1'b1, ADDR_ISTA, 32'h1 << EV_POR);
        @(posedge mclk);
        chk(32'(irq), 32'h0);
        // Count rate over a random span
        bus(1'b0, ADDR_CNT, 32'h0);
        p1 = pos(q);
        t0 = tk;
        g = 13'($random(seed));
        repeat (g) @(posedge mclk);
        bus(1'b0, ADDR_CNT, 32'h0);
        chk(32'((pos(q) - p1 + 262144) % 262144), 32'(tk - t0));
        // Service location read and write
        vec <= 8'($random(seed));
        bus(1'b0, ADDR_SVC, 32'h0);
        chk(q, {24'h0, vec});
        be <= 4'($random(seed));
        bus(1'b1, ADDR_SVC, $random(seed));
        be <= 4'hF;
        bus(1'b0, ADDR_CNT, 32'h0);
        chk(32'({q[21:16], q[12:5]}), 32'h0);
        bus(1'b0, ADDR_ISTA, 32'h0);
        chk(q, 32'h1 << EV_SVC);
        bus(1'b1, ADDR_ISTA, 32'h3);
        // Stop freezes the prescaler
        mode.stop <= 1'b1;
        bus(1'b0, ADDR_CNT, 32'h0);
        p1 = int'(q[12:0]);
        repeat (20) @(posedge mclk);
        bus(1'b0, ADDR_CNT, 32'h0);
        chk(32'(q[12:0]), 32'(p1));
        bus(1'b0, ADDR_STAT, 32'h0);
        chk(q, (32'h1 << STAT_STOP) | (32'h1 << STAT_PIN));
        mode.stop <= 1'b0;
        // Vector fetch clears the prescaler
        repeat (100) @(posedge mclk);
        mode.vfetch <= 1'b1;
        @(posedge mclk);
        mode.vfetch <= 1'b0;
        bus(1'b0, ADDR_CNT, 32'h0);
        chk(32'(q[12:0] < 13'h0008), 32'h1);
        // Internal reset, then a full timeout
        bus(1'b1, ADDR_IMSK, 32'h3);
        mode.int_reset <= 1'b1;
        @(posedge mclk);
        mode.int_reset <= 1'b0;
        @(posedge mclk);
        t0 = cyc;
        bus(1'b0, ADDR_CNT, 32'h0);
        chk(32'(q[21:0] < 22'h8), 32'h1);
        n = 0;
        while (chip_rst !== 1'b1 && n < 270000)
        begin
            @(posedge mclk);
            n++;
        end
        chk(32'(cyc - t0 >= 262128 && cyc - t0 <= 262152), 32'h1);
        chk(32'(irq), 32'h0);
        n = 0;
        while (pin_oe === 1'b1 && n < 100)
        begin
            @(posedge mclk);
            n++;
        end
        chk(32'(n), 32'(RST_PIN_CYCLES));
        repeat (8) @(posedge mclk);
        bus(1'b0, ADDR_STAT, 32'h0);
        chk(q, (32'h1 << STAT_CAUSE) | (32'h1 << STAT_PIN));
        bus(1'b1, ADDR_STAT, 32'h1 << STAT_CAUSE);
        // Each disable source, set then removed
        for (i = 0; i < 3; i++)
        begin
            if (i == 0)
                bus(1'b1, ADDR_CTRL, 32'h1 << CTRL_DIS);
            else if (i == 1)
                {mode.monitor, hv_irq} <= 2'b11;
            else
                {mode.brk, hv_rst} <= 2'b11;
            repeat (8) @(posedge mclk);
            bus(1'b0, ADDR_STAT, 32'h0);
            chk(32'(q[STAT_DIS]), 32'h1);
            bus(1'b1, ADDR_CTRL, 32'h0);
            mode <= '0;
            {hv_irq, hv_rst} <= 2'b00;
            repeat (8) @(posedge mclk);
            bus(1'b0, ADDR_STAT, 32'h0);
            chk(q, 32'h1 << STAT_PIN);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
